// >>> verilog/igp_port_cfg.sv
// Three-port indirect configuration registers with pin control and stop-mode wake.
`timescale 1ns/1ps
module igp_port_cfg
  import igp_pkg::*;
(
  // Clock, enable and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Package strap, caught after reset release
  input  wire logic        small_pkg,
  // Register file access
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  // Plain output data per port
  input  wire logic [23:0] port_out,
  // Alternate peripheral drive per port
  input  wire igp_alt_s    alt_a,
  input  wire igp_alt_s    alt_b,
  input  wire igp_alt_s    alt_c,
  // Timer direction for the shared timer pins (1 = output, 0 = input)
  input  wire logic        timer0_is_out,
  input  wire logic        timer1_is_out,
  // Stop mode
  input  wire logic        stop_mode,
  output logic             wake_req,
  // Pins
  input  wire logic [23:0] pin_i,
  output logic [23:0]      pin_o,
  output logic [23:0]      pin_oe,
  output logic [23:0]      pin_in_sync,
  output logic [23:0]      strong_drive,
  output logic [7:0]       led_drive_en
);
  logic [7:0]     sel_ff [IGP_NPORTS];
  igp_cfg_s       cfg_ff [IGP_NPORTS];
  logic [7:0]     rdata_ff;
  logic [23:0]    meta_ff;
  logic [23:0]    sync_ff;
  logic           strap_done_ff;
  logic [2:0]     wake_vec;
  logic [2:0]     sel_hit;
  logic [2:0]     ctl_hit;
  logic [7:0]     ctl_rd [IGP_NPORTS];
  logic [7:0]     nxt_rdata;
  igp_alt_s       alt_in [IGP_NPORTS];
  igp_alt_s       alt_a_fix;

  // Address decode.
  assign sel_hit[0] = (reg_addr == IGP_SEL_A_ADDR);
  assign sel_hit[1] = (reg_addr == IGP_SEL_B_ADDR);
  assign sel_hit[2] = (reg_addr == IGP_SEL_C_ADDR);
  assign ctl_hit[0] = (reg_addr == IGP_CTL_A_ADDR);
  assign ctl_hit[1] = (reg_addr == IGP_CTL_B_ADDR);
  assign ctl_hit[2] = (reg_addr == IGP_CTL_C_ADDR);

  // Shared timer pins: the timer decides input (no drive) or output of the peripheral level.
  always_comb begin
    alt_a_fix        = alt_a;
    alt_a_fix.oe[0]  = timer0_is_out & alt_a.oe[0];
    alt_a_fix.oe[6]  = timer1_is_out & alt_a.oe[6];
  end
  assign alt_in[0] = alt_a_fix;
  assign alt_in[1] = alt_b;
  assign alt_in[2] = alt_c;

  // Two-flop synchroniser for pin inputs; only sync_ff is used downstream.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= 24'h000000;
      sync_ff <= 24'h000000;
    end else if (ce) begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
    end
  end
  assign pin_in_sync = sync_ff;

  genvar p;
  generate
    for (p = 0; p < IGP_NPORTS; p++) begin : g_port
      logic ctl_wr;
      logic sel_ok;
      // Port A has no function-set subregisters at all.
      assign sel_ok = (sel_ff[p] >= IGP_SUB_DIR) &&
                      ((p == 0) ? (sel_ff[p] <= IGP_SUB_PULL) : (sel_ff[p] <= IGP_SUB_FS2));
      assign ctl_wr = ce & reg_wr & ctl_hit[p] & sel_ok;

      always_comb begin
        case (sel_ff[p])
          IGP_SUB_DIR:   ctl_rd[p] = cfg_ff[p].dir;
          IGP_SUB_ALT:   ctl_rd[p] = cfg_ff[p].alt;
          IGP_SUB_OD:    ctl_rd[p] = cfg_ff[p].od;
          IGP_SUB_DRIVE: ctl_rd[p] = cfg_ff[p].drive;
          IGP_SUB_WAKE:  ctl_rd[p] = cfg_ff[p].wake;
          IGP_SUB_PULL:  ctl_rd[p] = cfg_ff[p].pull;
          IGP_SUB_FS1:   ctl_rd[p] = (p == 0) ? 8'h00 : cfg_ff[p].fs1;
          IGP_SUB_FS2:   ctl_rd[p] = (p == 0) ? 8'h00 : cfg_ff[p].fs2;
          default:       ctl_rd[p] = 8'h00;
        endcase
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sel_ff[p] <= IGP_SEL_RESET;
        end else if (ce && reg_wr && sel_hit[p]) begin
          sel_ff[p] <= reg_wdata;
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cfg_ff[p] <= '{dir: IGP_DIR_RESET, alt: IGP_CFG_RESET, od: IGP_CFG_RESET,
                         drive: IGP_CFG_RESET, wake: IGP_CFG_RESET, pull: IGP_CFG_RESET,
                         fs1: IGP_CFG_RESET, fs2: IGP_CFG_RESET};
        end else if (ce && (p == 0) && !strap_done_ff) begin
          // Strap is caught on the first enabled edge after release, not in reset.
          cfg_ff[p].alt <= small_pkg ? IGP_AF_A_SMALL : IGP_CFG_RESET;
        end else if (ctl_wr) begin
          case (sel_ff[p])
            IGP_SUB_DIR:   cfg_ff[p].dir   <= reg_wdata;
            IGP_SUB_ALT:   cfg_ff[p].alt   <= reg_wdata;
            IGP_SUB_OD:    cfg_ff[p].od    <= reg_wdata;
            IGP_SUB_DRIVE: cfg_ff[p].drive <= reg_wdata;
            IGP_SUB_WAKE:  cfg_ff[p].wake  <= reg_wdata;
            IGP_SUB_PULL:  cfg_ff[p].pull  <= reg_wdata;
            IGP_SUB_FS1:   cfg_ff[p].fs1   <= reg_wdata;
            IGP_SUB_FS2:   cfg_ff[p].fs2   <= reg_wdata;
            default:       cfg_ff[p].pull  <= cfg_ff[p].pull;
          endcase
        end
      end

      igp_pin_ctrl u_pin (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .cfg       (cfg_ff[p]),
        .port_out  (port_out[8*p +: 8]),
        .alt       (alt_in[p]),
        .pin_sync  (sync_ff[8*p +: 8]),
        .stop_mode (stop_mode),
        .pin_o     (pin_o[8*p +: 8]),
        .pin_oe    (pin_oe[8*p +: 8]),
        .wake_req  (wake_vec[p])
      );
      assign strong_drive[8*p +: 8] = cfg_ff[p].drive;
    end
  endgenerate

  // Port C's strong-drive bits also select LED current sinking where its alternate bits are set.
  assign led_drive_en = cfg_ff[2].drive & cfg_ff[2].alt;
  assign wake_req     = |wake_vec;

  // Read data is registered: valid the cycle after reg_rd.
  assign nxt_rdata = sel_hit[0] ? sel_ff[0] :
                     sel_hit[1] ? sel_ff[1] :
                     sel_hit[2] ? sel_ff[2] :
                     ctl_hit[0] ? ctl_rd[0] :
                     ctl_hit[1] ? ctl_rd[1] :
                     ctl_hit[2] ? ctl_rd[2] : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff      <= 8'h00;
      strap_done_ff <= 1'b0;
    end else if (ce) begin
      strap_done_ff <= 1'b1;
      if (reg_rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end
  assign reg_rdata = rdata_ff;

  sequence s_sel_zero_write;
    (sel_ff[0] == 8'h00) && ce && reg_wr && ctl_hit[0] && strap_done_ff;
  endsequence
  property p_null_no_write;
    @(posedge clk) disable iff (rst) s_sel_zero_write |=> $stable(cfg_ff[0]);
  endproperty
  a_null_no_write: assert property (p_null_no_write) else $error("Null selector changed config.");

  property p_null_read_zero;
    @(posedge clk) disable iff (rst) (ce && reg_rd && ctl_hit[1] && sel_ff[1] == 8'h00) |=> (reg_rdata == 8'h00);
  endproperty
  a_null_read_zero: assert property (p_null_read_zero) else $error("Null selector read not zero.");

  property p_sel_write;
    @(posedge clk) disable iff (rst) (ce && reg_wr && sel_hit[2]) |=> (sel_ff[2] == $past(reg_wdata));
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("Selector write lost.");

  sequence s_od_write;
    ce && reg_wr && ctl_hit[1] && sel_ff[1] == 8'h03 && strap_done_ff;
  endsequence
  property p_od_route;
    @(posedge clk) disable iff (rst) s_od_write |=> (cfg_ff[1].od == $past(reg_wdata));
  endproperty
  a_od_route: assert property (p_od_route) else $error("Open-drain write misrouted.");

  property p_strap;
    @(posedge clk) disable iff (rst) (ce && !strap_done_ff) |=> (cfg_ff[0].alt == ($past(small_pkg) ? 8'h04 : 8'h00));
  endproperty
  a_strap: assert property (p_strap) else $error("Alternate reset value wrong.");

  property p_wake_stop_only;
    @(posedge clk) disable iff (rst) !stop_mode |-> !wake_req;
  endproperty
  a_wake_stop_only: assert property (p_wake_stop_only) else $error("Wake outside stop mode.");
endmodule : igp_port_cfg

// >>> verilog/igp_pkg.sv
// Package of addresses, subregister codes and resets for the indirect port configuration block.
package igp_pkg;
  localparam int          IGP_NPORTS       = 3;
  localparam logic [11:0] IGP_SEL_A_ADDR   = 12'hFD0;
  localparam logic [11:0] IGP_SEL_B_ADDR   = 12'hFD4;
  localparam logic [11:0] IGP_SEL_C_ADDR   = 12'hFD8;
  localparam logic [11:0] IGP_CTL_A_ADDR   = 12'hFD1;
  localparam logic [11:0] IGP_CTL_B_ADDR   = 12'hFD5;
  localparam logic [11:0] IGP_CTL_C_ADDR   = 12'hFD9;
  localparam logic [7:0]  IGP_SEL_RESET    = 8'h00;
  localparam logic [7:0]  IGP_CFG_RESET    = 8'h00;
  localparam logic [7:0]  IGP_AF_A_SMALL   = 8'h04;
  localparam logic [7:0]  IGP_DIR_RESET    = 8'hFF;
  localparam logic [7:0]  IGP_LED_RESET    = 8'h00;

  typedef enum logic [7:0] {
    IGP_SUB_NONE  = 8'h00,
    IGP_SUB_DIR   = 8'h01,
    IGP_SUB_ALT   = 8'h02,
    IGP_SUB_OD    = 8'h03,
    IGP_SUB_DRIVE = 8'h04,
    IGP_SUB_WAKE  = 8'h05,
    IGP_SUB_PULL  = 8'h06,
    IGP_SUB_FS1   = 8'h07,
    IGP_SUB_FS2   = 8'h08
  } igp_sub_e;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] alt;
    logic [7:0] od;
    logic [7:0] drive;
    logic [7:0] wake;
    logic [7:0] pull;
    logic [7:0] fs1;
    logic [7:0] fs2;
  } igp_cfg_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } igp_alt_s;
endpackage : igp_pkg

// >>> verilog/igp_pin_ctrl.sv
// One port's pin drive resolution and stop-mode wake detection.
`timescale 1ns/1ps
module igp_pin_ctrl
  import igp_pkg::*;
(
  // Clock, enable and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Configuration and data
  input  wire igp_cfg_s   cfg,
  input  wire logic [7:0] port_out,
  input  wire igp_alt_s   alt,
  input  wire logic [7:0] pin_sync,
  input  wire logic       stop_mode,
  // Pins
  output logic [7:0]      pin_o,
  output logic [7:0]      pin_oe,
  output logic            wake_req
);
  logic [7:0] prev_ff;
  logic [7:0] want_oe;
  logic [7:0] want_out;
  logic [7:0] edge_hit;

  // Alternate function owns the pin when enabled, else direction bit (1 = input).
  assign want_oe  = (cfg.alt & alt.oe) | (~cfg.alt & ~cfg.dir);
  assign want_out = (cfg.alt & alt.out) | (~cfg.alt & port_out);
  assign pin_o    = want_out;
  // Open-drain drops the high side even for peripherals: drive only the low level.
  assign pin_oe   = want_oe & ~(cfg.od & want_out);
  assign edge_hit = (pin_sync ^ prev_ff) & cfg.wake;
  assign wake_req = stop_mode & (|edge_hit);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_ff <= 8'h00;
    end else if (ce) begin
      prev_ff <= pin_sync;
    end
  end

  property p_od_no_high;
    @(posedge clk) disable iff (rst) (cfg.od != 8'h00) |-> ((pin_oe & cfg.od & pin_o) == 8'h00);
  endproperty
  a_od_no_high: assert property (p_od_no_high) else $error("Open-drain pin drove high.");

  property p_plain_dir;
    @(posedge clk) disable iff (rst) (cfg.alt == 8'h00 && cfg.od == 8'h00) |-> (pin_oe == ~cfg.dir);
  endproperty
  a_plain_dir: assert property (p_plain_dir) else $error("Plain pin direction wrong.");

  property p_alt_owns;
    @(posedge clk) disable iff (rst) (cfg.alt == 8'hFF) |-> ((pin_o == alt.out) && ((pin_oe & ~alt.oe) == 8'h00));
  endproperty
  a_alt_owns: assert property (p_alt_owns) else $error("Alternate function not in control.");

  property p_no_wake_disabled;
    @(posedge clk) disable iff (rst) (cfg.wake == 8'h00) |-> !wake_req;
  endproperty
  a_no_wake_disabled: assert property (p_no_wake_disabled) else $error("Wake from disabled pin.");
endmodule : igp_pin_ctrl

// >>> tb/igp_pins_model.sv
// Model of the pins and alternate peripherals outside the port block.
`timescale 1ns/1ps
module igp_pins_model
  import igp_pkg::*;
(
  // Pin wires
  input  wire logic [23:0] pin_o,
  input  wire logic [23:0] pin_oe,
  input  wire logic [23:0] ext_lvl,
  output logic [23:0]      pin_i,
  // Peripheral drive
  output igp_alt_s         alt_a,
  output igp_alt_s         alt_b,
  output igp_alt_s         alt_c
);
  // A driven pin reads back its own level; an undriven one shows the outside level.
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
  // Peripherals always want to drive, so only the block's enables decide the pin.
  assign alt_a = '{out: 8'h55, oe: 8'hFF};
  assign alt_b = '{out: 8'h55, oe: 8'hFF};
  assign alt_c = '{out: 8'h55, oe: 8'hFF};
endmodule : igp_pins_model

// >>> tb/indirect_gpio_port_config_test.sv
// Self-checking bench for the indirect port configuration block.
`timescale 1ns/1ps
module indirect_gpio_port_config_test
  import igp_pkg::*;
;
  logic        clk, rst, ce, small_pkg, reg_wr, reg_rd, stop_mode, t0_out, t1_out, wake_req;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, led_drive_en;
  logic [23:0] port_out, ext_lvl, pin_i, pin_o, pin_oe, pin_in_sync, strong_drive;
  igp_alt_s    alt_a, alt_b, alt_c;
  int          errors = 0;
  int          checked = 0;
  int          n;
  logic [7:0]  vals [5] = '{8'hFF, 8'h00, 8'h5A, 8'h3C, 8'h01};

  igp_port_cfg DUT (.clk(clk), .rst(rst), .ce(ce), .small_pkg(small_pkg), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .port_out(port_out),
    .alt_a(alt_a), .alt_b(alt_b), .alt_c(alt_c), .timer0_is_out(t0_out), .timer1_is_out(t1_out),
    .stop_mode(stop_mode), .wake_req(wake_req), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_in_sync(pin_in_sync), .strong_drive(strong_drive), .led_drive_en(led_drive_en));
  igp_pins_model pins (.pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_i(pin_i),
    .alt_a(alt_a), .alt_b(alt_b), .alt_c(alt_c));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic conclude;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data is registered, so it is sampled on the falling edge after the read edge.
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", 24'(reg_rdata), 24'(exp));
  endtask : rdc

  // Toggles one pin and counts the wake pulses seen over the next six cycles.
  task automatic wk(input int b, input int exp);
    @(posedge clk);
    ext_lvl[b] <= ~ext_lvl[b];
    n = 0;
    repeat (6) begin
      @(negedge clk);
      if (wake_req === 1'b1) n++;
    end
    chk("wake_req", 24'(n), 24'(exp));
  endtask : wk

  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    conclude();
  end

  initial begin
    rst = 1'b1; ce = 1'b1; small_pkg = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; stop_mode = 1'b0;
    reg_addr = 12'h000; reg_wdata = 8'h00; t0_out = 1'b0; t1_out = 1'b0;
    port_out = 24'h00F000; ext_lvl = 24'h000000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("pin_oe", pin_oe, 24'h000004);
    rdc(IGP_SEL_A_ADDR, IGP_SEL_RESET);
    rdc(IGP_SEL_B_ADDR, 8'h00);
    rdc(IGP_SEL_C_ADDR, 8'h00);
    rdc(IGP_CTL_A_ADDR, 8'h00);
    rdc(IGP_CTL_B_ADDR, 8'h00);
    wr(IGP_CTL_A_ADDR, 8'h00);
    wr(IGP_SEL_A_ADDR, 8'h01);
    rdc(IGP_CTL_A_ADDR, IGP_DIR_RESET);
    wr(IGP_SEL_A_ADDR, 8'h02);
    rdc(IGP_SEL_A_ADDR, 8'h02);
    rdc(IGP_CTL_A_ADDR, IGP_AF_A_SMALL);
    wr(IGP_SEL_B_ADDR, 8'h02);
    rdc(IGP_CTL_B_ADDR, 8'h00);
    wr(IGP_SEL_B_ADDR, 8'h03);
    rdc(IGP_CTL_B_ADDR, 8'h00);
    wr(IGP_SEL_B_ADDR, 8'h05);
    rdc(IGP_CTL_B_ADDR, 8'h00);
    for (n = 1; n <= 5; n++) begin
      wr(IGP_SEL_C_ADDR, 8'(n));
      wr(IGP_CTL_C_ADDR, vals[n-1]);
    end
    for (n = 1; n <= 5; n++) begin
      wr(IGP_SEL_C_ADDR, 8'(n));
      rdc(IGP_CTL_C_ADDR, vals[n-1]);
    end
    chk("strong_drive", 24'(strong_drive[23:16]), 24'h00003C);
    chk("led_drive_en", 24'(led_drive_en), 24'h000000);
    wr(IGP_SEL_A_ADDR, 8'h07);
    wr(IGP_CTL_A_ADDR, 8'hA5);
    rdc(IGP_CTL_A_ADDR, 8'h00);
    wr(IGP_SEL_B_ADDR, 8'h08);
    wr(IGP_CTL_B_ADDR, 8'hA5);
    rdc(IGP_CTL_B_ADDR, 8'hA5);
    wr(IGP_SEL_B_ADDR, 8'h09);
    wr(IGP_CTL_B_ADDR, 8'hA5);
    rdc(IGP_CTL_B_ADDR, 8'h00);
    wr(IGP_SEL_B_ADDR, 8'h01);
    wr(IGP_CTL_B_ADDR, 8'h00);
    @(negedge clk);
    chk("pin_oe", 24'(pin_oe[15:8]), 24'h0000FF);
    chk("pin_o", 24'(pin_o[15:8]), 24'h0000F0);
    wr(IGP_SEL_B_ADDR, 8'h03);
    wr(IGP_CTL_B_ADDR, 8'hF1);
    @(negedge clk);
    chk("pin_oe", 24'(pin_oe[15:8]), 24'h00000F);
    wr(IGP_SEL_B_ADDR, 8'h02);
    wr(IGP_CTL_B_ADDR, 8'h0F);
    @(negedge clk);
    chk("pin_oe", 24'(pin_oe[15:8]), 24'h00000E);
    chk("pin_o", 24'(pin_o[11:8]), 24'h000005);
    wr(IGP_SEL_A_ADDR, 8'h02);
    wr(IGP_CTL_A_ADDR, 8'h05);
    @(negedge clk);
    chk("pin_oe", 24'(pin_oe[7:0]), 24'h000004);
    @(posedge clk);
    t0_out <= 1'b1;
    @(negedge clk);
    chk("pin_oe", 24'(pin_oe[7:0]), 24'h000005);
    wk(16, 0);
    @(posedge clk);
    stop_mode <= 1'b1;
    wk(16, 1);
    wk(17, 0);
    chk("pin_in_sync", 24'(pin_in_sync[23:16]), 24'h000002);
    conclude();
  end
endmodule : indirect_gpio_port_config_test
